// *** fcsm_highway.sv ***
// Purpose: highway controller model feeding one timeslot per cycle
// Assumes: changes only just after rising edges of core_clk
// Notes:   flag value is copied onto all stream bits, position moot
module fcsm_highway (
	input  wire logic       core_clk,
	input  wire logic       run,
	output logic [4:0]      slot_channel,
	output logic            slot_valid,
	output logic            flexible_serial_pin,
	output logic [4:0]      serial_ctrl_pins,
	output logic [7:0]      channel_control_stream
);
	timeunit 1ns;
	timeprecision 1ns;
	// quiet lines at time zero
	initial begin
		slot_valid = 1'b0;
		slot_channel = '0;
		flexible_serial_pin = 1'b0;
		serial_ctrl_pins = '0;
		channel_control_stream = '0;
	end
	// random slot contents, valid only while running
	always @(posedge core_clk) begin
		slot_valid <= run;
		slot_channel <= 5'($urandom);
		flexible_serial_pin <= 1'($urandom);
		serial_ctrl_pins <= 5'($urandom);
		channel_control_stream <= {8{1'($urandom)}};
	end
endmodule

// *** fcsm_pkg.sv ***
// Purpose: shared constants and types for the flexible control source mapper
// Assumes: avalon-mm slave with 32-bit data, byte addresses = index * 4
// Notes:   printed offsets are register indices, not byte addresses
package fcsm_pkg;
	// register indices as printed
	localparam logic [7:0] IDX_SERIAL_PIN_MASK  = 8'h6B;
	localparam logic [7:0] IDX_PIN_FUNC_SEL     = 8'h6C;
	localparam logic [7:0] IDX_FLAG_FUNC_SEL    = 8'h6D;
	localparam logic [7:0] IDX_MONITOR_SEL      = 8'h6F;
	// extra control registers
	localparam logic [7:0] IDX_PRIORITY_CTRL    = 8'h70;
	localparam logic [7:0] IDX_REG_ACTIONS      = 8'h71;
	localparam logic [7:0] IDX_FLAG_POS_SEL     = 8'h72;
	localparam logic [7:0] IDX_WRITE_UNLOCK     = 8'h73;
	localparam logic [7:0] IDX_ACTION_STATUS    = 8'h74;
	// reset values
	localparam logic [5:0] RST_SERIAL_PIN_MASK  = 6'h3F;
	localparam logic [5:0] RST_PIN_FUNC_SEL     = 6'h00;
	localparam logic [5:0] RST_FLAG_FUNC_SEL    = 6'h00;
	localparam logic [7:0] RST_MONITOR_SEL      = 8'hFE;
	localparam logic [7:0] UNLOCK_KEY           = 8'hA5;
	// function field positions (bypass at top, conversion at bottom)
	localparam int FB_BYPASS   = 5;
	localparam int FB_NLPDIS   = 4;
	localparam int FB_HOLD     = 3;
	localparam int FB_METER    = 2;
	localparam int FB_CLEAR    = 1;
	localparam int FB_CONVOFF  = 0;
	// serial pin mask: bit of the flexible pin
	localparam int MB_FLEX_PIN = 0;
	localparam int NUM_ACT     = 6;
	localparam int FLAG_W      = 8;
	localparam int FPOS_W      = 2;
	// one set of canceller actions for one channel
	typedef struct packed {
		logic bypass;
		logic nonlinear_off;
		logic coeff_hold;
		logic meter_reset;
		logic coeff_clear;
		logic law_conv_off;
	} fcsm_act_s;
	// avalon request bundle
	typedef struct packed {
		logic        read;
		logic        write;
		logic [9:0]  address;
		logic [31:0] writedata;
	} fcsm_req_s;
endpackage

// *** fcsm_top.sv ***
// Purpose: flexible control source mapping registers and per-slot action OR
// Assumes: inputs synchronous to core_clk; one channel timeslot per cycle
// Notes:   register writes need the unlock key written first
// Summary of operation
// - six-bit mask suppresses serial control pins
// - reset: mask 3F, both selects cleared
// - pin select acts only when mask clear
// - pin with bypass bit bypasses whole path
// - pin with nonlinear bit disables processor, attenuator
// - pin with hold bit freezes coefficients
// - pin with meter bit resets speech meters
// - pin with clear bit clears coefficients
// - pin with conversion bit disables law conversion
// - second register selects flag functions, position; code takes position from its own register 72
// - flag with bypass bit bypasses whole path
// - flag with nonlinear bit disables processor
// - flag with hold bit freezes coefficients
// - flag with meter bit resets meters
// - flag with clear bit clears coefficients
// - flag with conversion bit disables conversion
// - priority bit ignores hardware sources, else OR
// - monitor select holds two four-bit codes
//
// Register access over Avalon-MM was left to the implementer.
module fcsm_top #(
	parameter int NCH = 32,
	parameter int CHW = 5
) (
	input  wire logic                  core_clk,
	input  wire logic                  nrst,
	input  wire fcsm_pkg::fcsm_req_s   avs_req,
	output logic [31:0]                avs_readdata,
	output logic                       avs_waitrequest,
	input  wire logic [CHW-1:0]        slot_channel,
	input  wire logic                  slot_valid,
	input  wire logic                  flexible_serial_pin,
	input  wire logic [4:0]            serial_ctrl_pins,
	input  wire logic [fcsm_pkg::FLAG_W-1:0] channel_control_stream,
	input  wire fcsm_pkg::fcsm_act_s   other_hw_act,
	output fcsm_pkg::fcsm_act_s        act_out,
	output logic [CHW-1:0]             act_channel,
	output logic                       act_valid,
	output logic [4:0]                 serial_pins_eff,
	output logic [3:0]                 monitor_one_sel,
	output logic [3:0]                 monitor_two_sel
);
	import fcsm_pkg::*;

	// configuration registers
	logic [5:0]     pin_mask_ff;        // serial pin mask
	logic [5:0]     pin_sel_ff;         // pin function select
	logic [5:0]     flag_sel_ff;        // stream flag function select
	logic [7:0]     mon_sel_ff;         // monitor select
	logic [NCH-1:0] prio_ff;            // per-channel priority control
	logic [5:0]     reg_act_ff;         // register action bits (all channels)
	logic [FPOS_W-1:0] fpos_ff;         // flag position select
	logic           unlock_ff;          // write protection open
	logic           ack_ff;             // access answered this cycle
	logic [31:0]    rdata_ff;           // read data
	fcsm_act_s      act_ff;             // resolved actions
	logic [CHW-1:0] ach_ff;             // channel of resolved actions
	logic           avl_ff;             // resolved actions valid
	logic [4:0]     spe_ff;             // effective serial pins

	// bus decode
	wire logic [7:0] idx      = avs_req.address[9:2];
	wire logic       access   = (avs_req.read | avs_req.write) & ~ack_ff;
	// a write lands at the edge where waitrequest is seen low
	wire logic       wr_go    = avs_req.write & ack_ff;
	wire logic       wr_prot  = wr_go & unlock_ff;
	wire logic       wr_key   = wr_go & (idx == IDX_WRITE_UNLOCK);

	// decode of one register index, reused for each register
	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		hit = (a == r);
	endfunction

	// channel selection of priority bit
	wire logic prio_now = prio_ff[slot_channel];

	// pin source: active only with its mask bit clear
	wire logic pin_on  = flexible_serial_pin & ~pin_mask_ff[MB_FLEX_PIN];
	// flag source: bit picked by position select
	wire logic flag_bit = channel_control_stream[fpos_ff];
	wire logic [5:0] pin_req  = pin_on ? pin_sel_ff : 6'h00;
	wire logic [5:0] flag_req = flag_bit ? flag_sel_ff : 6'h00;
	wire logic [5:0] hw_req   = pin_req | flag_req | other_hw_act;
	wire logic [5:0] act_nxt  = prio_now ? reg_act_ff
	                                     : (reg_act_ff | hw_req);
	wire logic [4:0] sp_nxt   = serial_ctrl_pins & ~pin_mask_ff[5:1];

	// read mux
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit(idx, IDX_SERIAL_PIN_MASK))
			rd_mux = {26'h0, pin_mask_ff};
		else if (hit(idx, IDX_PIN_FUNC_SEL))
			rd_mux = {26'h0, pin_sel_ff};
		else if (hit(idx, IDX_FLAG_FUNC_SEL))
			rd_mux = {26'h0, flag_sel_ff};
		else if (hit(idx, IDX_MONITOR_SEL))
			rd_mux = {24'h0, mon_sel_ff};
		else if (hit(idx, IDX_PRIORITY_CTRL))
			rd_mux = 32'(prio_ff);
		else if (hit(idx, IDX_REG_ACTIONS))
			rd_mux = {26'h0, reg_act_ff};
		else if (hit(idx, IDX_FLAG_POS_SEL))
			rd_mux = {30'h0, fpos_ff};
		else if (hit(idx, IDX_WRITE_UNLOCK))
			rd_mux = {31'h0, unlock_ff};
		else if (hit(idx, IDX_ACTION_STATUS))
			rd_mux = {26'h0, act_ff};
	end

	// bus handshake: one wait cycle, answer on the second
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ack_ff   <= 1'b0;
			rdata_ff <= 32'h0000_0000;
		end else begin
			ack_ff   <= access;
			rdata_ff <= access ? rd_mux : rdata_ff;
		end
	end

	// write-protected configuration registers
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			pin_mask_ff <= RST_SERIAL_PIN_MASK;
			pin_sel_ff  <= RST_PIN_FUNC_SEL;
			flag_sel_ff <= RST_FLAG_FUNC_SEL;
			mon_sel_ff  <= RST_MONITOR_SEL;
			prio_ff     <= '0;
			reg_act_ff  <= 6'h00;
			fpos_ff     <= '0;
		end else if (wr_prot) begin
			if (hit(idx, IDX_SERIAL_PIN_MASK))
				pin_mask_ff <= avs_req.writedata[5:0];
			if (hit(idx, IDX_PIN_FUNC_SEL))
				pin_sel_ff <= avs_req.writedata[5:0];
			if (hit(idx, IDX_FLAG_FUNC_SEL))
				flag_sel_ff <= avs_req.writedata[5:0];
			if (hit(idx, IDX_MONITOR_SEL))
				mon_sel_ff <= avs_req.writedata[7:0];
			if (hit(idx, IDX_PRIORITY_CTRL))
				prio_ff <= avs_req.writedata[NCH-1:0];
			if (hit(idx, IDX_REG_ACTIONS))
				reg_act_ff <= avs_req.writedata[5:0];
			if (hit(idx, IDX_FLAG_POS_SEL))
				fpos_ff <= avs_req.writedata[FPOS_W-1:0];
		end
	end

	// unlock opens on the key, closes on any other value
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst)
			unlock_ff <= 1'b0;
		else if (wr_key)
			unlock_ff <= (avs_req.writedata[7:0] == UNLOCK_KEY);
	end

	// per-slot action resolution, one cycle latency
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			act_ff <= '0;
			ach_ff <= '0;
			avl_ff <= 1'b0;
			spe_ff <= 5'h00;
		end else begin
			act_ff <= slot_valid ? fcsm_act_s'(act_nxt) : act_ff;
			ach_ff <= slot_valid ? slot_channel : ach_ff;
			avl_ff <= slot_valid;
			spe_ff <= sp_nxt;
		end
	end

	// outputs
	assign avs_waitrequest = ~ack_ff & ~(avs_req.read | avs_req.write) ? 1'b1
	                        : ~ack_ff;
	assign avs_readdata    = rdata_ff;
	assign act_out         = act_ff;
	assign act_channel     = ach_ff;
	assign act_valid       = avl_ff;
	assign serial_pins_eff = spe_ff;
	assign monitor_one_sel = mon_sel_ff[7:4];
	assign monitor_two_sel = mon_sel_ff[3:0];

	// assertions
	property p_reset_vals;
		@(posedge core_clk) $rose(nrst) |-> pin_mask_ff == RST_SERIAL_PIN_MASK
			&& pin_sel_ff == 6'h00 && flag_sel_ff == 6'h00;
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");

	property p_mask_blocks;
		@(posedge core_clk) disable iff (!nrst)
		slot_valid && pin_mask_ff[0] && !prio_now && flag_sel_ff == 6'h00
			&& reg_act_ff == 6'h00 && other_hw_act == '0 |=> act_ff == '0;
	endproperty
	a_mask_blocks: assert property (p_mask_blocks) else $error("masked pin acted");

	property p_pin_maps;
		@(posedge core_clk) disable iff (!nrst)
		slot_valid && pin_on && !prio_now |=> (act_ff & pin_sel_ff) == pin_sel_ff;
	endproperty
	a_pin_maps: assert property (p_pin_maps) else $error("pin action missing");

	property p_flag_maps;
		@(posedge core_clk) disable iff (!nrst)
		slot_valid && flag_bit && !prio_now
			|=> (act_ff & flag_sel_ff) == flag_sel_ff;
	endproperty
	a_flag_maps: assert property (p_flag_maps) else $error("flag action missing");

	property p_prio_only_reg;
		@(posedge core_clk) disable iff (!nrst)
		slot_valid && prio_now ##1 1'b1 |-> act_ff == $past(reg_act_ff);
	endproperty
	a_prio_only_reg: assert property (p_prio_only_reg) else $error("priority leak");

	property p_mon_split;
		@(posedge core_clk) disable iff (!nrst)
		{monitor_one_sel, monitor_two_sel} == mon_sel_ff;
	endproperty
	a_mon_split: assert property (p_mon_split) else $error("monitor split");

	sequence s_req;
		(avs_req.read || avs_req.write) && !ack_ff;
	endsequence
	property p_answer;
		@(posedge core_clk) disable iff (!nrst)
		s_req |=> !avs_waitrequest;
	endproperty
	a_answer: assert property (p_answer) else $error("no bus answer");

	property p_mask_pins;
		@(posedge core_clk) disable iff (!nrst)
		1'b1 |=> (serial_pins_eff & $past(pin_mask_ff[5:1])) == 5'h00;
	endproperty
	a_mask_pins: assert property (p_mask_pins) else $error("masked pin passed");

	// per-action checks: a slot in which the pin is live and
	// hardware sources count, so the pin select must show up
	sequence s_pin_slot;
		slot_valid && pin_on && !prio_now;
	endsequence

	// a slot in which the chosen stream flag is live
	sequence s_flag_slot;
		slot_valid && flag_bit && !prio_now;
	endsequence

	// pin bypass request reaches the slot result
	property p_pin_byp;
		@(posedge core_clk) disable iff (!nrst)
		s_pin_slot ##0 pin_sel_ff[FB_BYPASS] |=> act_ff.bypass;
	endproperty
	a_pin_byp: assert property (p_pin_byp) else $error("pin bypass lost");

	// pin nonlinear disable request reaches the slot result
	property p_pin_nlp;
		@(posedge core_clk) disable iff (!nrst)
		s_pin_slot ##0 pin_sel_ff[FB_NLPDIS] |=> act_ff.nonlinear_off;
	endproperty
	a_pin_nlp: assert property (p_pin_nlp) else $error("pin nlp lost");

	// pin hold request freezes the coefficients
	property p_pin_hold;
		@(posedge core_clk) disable iff (!nrst)
		s_pin_slot ##0 pin_sel_ff[FB_HOLD] |=> act_ff.coeff_hold;
	endproperty
	a_pin_hold: assert property (p_pin_hold) else $error("pin hold lost");

	// pin meter request resets the speech meters
	property p_pin_meter;
		@(posedge core_clk) disable iff (!nrst)
		s_pin_slot ##0 pin_sel_ff[FB_METER] |=> act_ff.meter_reset;
	endproperty
	a_pin_meter: assert property (p_pin_meter) else $error("pin meter");

	// pin clear request clears the coefficients
	property p_pin_clr;
		@(posedge core_clk) disable iff (!nrst)
		s_pin_slot ##0 pin_sel_ff[FB_CLEAR] |=> act_ff.coeff_clear;
	endproperty
	a_pin_clr: assert property (p_pin_clr) else $error("pin clear lost");

	// pin conversion request turns law conversion off
	property p_pin_conv;
		@(posedge core_clk) disable iff (!nrst)
		s_pin_slot ##0 pin_sel_ff[FB_CONVOFF] |=> act_ff.law_conv_off;
	endproperty
	a_pin_conv: assert property (p_pin_conv) else $error("pin conv lost");

	// with only the pin as source, unselected actions stay off
	property p_pin_only;
		@(posedge core_clk) disable iff (!nrst)
		slot_valid && !prio_now && flag_req == 6'h00
			&& other_hw_act == '0 && reg_act_ff == 6'h00
			|=> act_ff == $past(pin_req);
	endproperty
	a_pin_only: assert property (p_pin_only) else $error("pin extra act");

	// flag nonlinear disable request reaches the slot result
	property p_flag_nlp;
		@(posedge core_clk) disable iff (!nrst)
		s_flag_slot ##0 flag_sel_ff[FB_NLPDIS] |=> act_ff.nonlinear_off;
	endproperty
	a_flag_nlp: assert property (p_flag_nlp) else $error("flag nlp");

	// flag hold request freezes the coefficients
	property p_flag_hold;
		@(posedge core_clk) disable iff (!nrst)
		s_flag_slot ##0 flag_sel_ff[FB_HOLD] |=> act_ff.coeff_hold;
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag hold");

	// flag meter request resets the speech meters
	property p_flag_meter;
		@(posedge core_clk) disable iff (!nrst)
		s_flag_slot ##0 flag_sel_ff[FB_METER] |=> act_ff.meter_reset;
	endproperty
	a_flag_meter: assert property (p_flag_meter) else $error("flag mtr");

	// flag clear request clears the coefficients
	property p_flag_clr;
		@(posedge core_clk) disable iff (!nrst)
		s_flag_slot ##0 flag_sel_ff[FB_CLEAR] |=> act_ff.coeff_clear;
	endproperty
	a_flag_clr: assert property (p_flag_clr) else $error("flag clear");

	// flag conversion request turns law conversion off
	property p_flag_conv;
		@(posedge core_clk) disable iff (!nrst)
		s_flag_slot ##0 flag_sel_ff[FB_CONVOFF] |=> act_ff.law_conv_off;
	endproperty
	a_flag_conv: assert property (p_flag_conv) else $error("flag conv");

	// with only the flag as source, unselected actions stay off
	property p_flag_only;
		@(posedge core_clk) disable iff (!nrst)
		slot_valid && !prio_now && pin_req == 6'h00
			&& other_hw_act == '0 && reg_act_ff == 6'h00
			|=> act_ff == $past(flag_req);
	endproperty
	a_flag_only: assert property (p_flag_only) else $error("flag extra");

	// in a slot without priority, every requesting hardware source shows in the result
	property p_any_src;
		@(posedge core_clk) disable iff (!nrst)
		slot_valid && !prio_now
			|=> (act_ff & $past(hw_req)) == $past(hw_req);
	endproperty
	a_any_src: assert property (p_any_src) else $error("source lost");

	// no slot, no change of the resolved actions
	property p_act_hold;
		@(posedge core_clk) disable iff (!nrst)
		!slot_valid |=> $stable(act_ff);
	endproperty
	a_act_hold: assert property (p_act_hold) else $error("act moved");

	// monitor select comes out of reset with its documented codes
	property p_mon_reset;
		@(posedge core_clk) $rose(nrst) |-> mon_sel_ff == RST_MONITOR_SEL;
	endproperty
	a_mon_reset: assert property (p_mon_reset) else $error("mon reset");

	// a locked write leaves the pin select alone
	property p_wr_locked;
		@(posedge core_clk) disable iff (!nrst)
		wr_go && !unlock_ff && hit(idx, IDX_PIN_FUNC_SEL)
			|=> $stable(pin_sel_ff);
	endproperty
	a_wr_locked: assert property (p_wr_locked) else $error("locked write");
endmodule

// *** flex_control_source_mapping_bench.sv ***
// Purpose: self-checking bench of the source mapper
// Assumes: registers opened with the unlock key before writes
// Notes:   expected actions queued per slot, popped per result
module flex_control_source_mapping_bench;
	import fcsm_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic             core_clk = 1'b0;
	logic             nrst = 1'b0;
	logic             run = 1'b0;
	fcsm_req_s        avs_req = '0;
	logic [31:0]      avs_readdata, rd;
	logic             avs_waitrequest, slot_valid, flexible_serial_pin;
	logic             act_valid, prio = 1'b0;
	logic [4:0]       slot_channel, serial_ctrl_pins, serial_pins_eff;
	logic [4:0]       act_channel;
	logic [7:0]       channel_control_stream, m;
	logic [3:0]       monitor_one_sel, monitor_two_sel;
	fcsm_act_s        act_out;
	logic [5:0]       msk = 6'h3F, psel = '0, fsel = '0;
	logic [5:0]       hwm = '0, ract = '0;
	fcsm_act_s        hw = '0;
	logic [15:0]      exp_q[$], e;
	int               failures = 0, tests_run = 0;
	always #4 core_clk = ~core_clk;
	fcsm_top i_dut (.core_clk, .nrst, .avs_req, .avs_readdata,
		.avs_waitrequest, .slot_channel, .slot_valid, .flexible_serial_pin,
		.serial_ctrl_pins, .channel_control_stream, .other_hw_act(hw),
		.act_out, .act_channel, .act_valid, .serial_pins_eff,
		.monitor_one_sel, .monitor_two_sel);
	fcsm_highway i_hwy (.core_clk, .run, .slot_channel, .slot_valid,
		.flexible_serial_pin, .serial_ctrl_pins, .channel_control_stream);
	task print_verdict;
		$display("compared %0d, bad %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task cmp(input logic [31:0] g, input logic [31:0] x);
		tests_run++;
		if (g !== x) begin
			failures++;
			$display("BAD %0t reg got %h want %h", $time, g, x);
		end
	endtask
	task cmpa(input logic [15:0] g, input logic [15:0] x);
		tests_run++;
		if (g !== x) begin
			failures++;
			$display("BAD %0t act got %h want %h", $time, g, x);
		end
	endtask
	// one avalon access, held until waitrequest is seen low
	task xfer(input logic w, input logic [7:0] ix, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		avs_req <= '{read: !w, write: w, address: {ix, 2'b00}, writedata: d};
		for (n = 0; n < 50; n++) begin
			@(posedge core_clk);
			if (avs_waitrequest === 1'b0) break;
		end
		if (n == 50) begin
			failures++;
			print_verdict();
		end
		rd = avs_readdata;
		avs_req <= '0;
	endtask
	task rdc(input logic [7:0] ix, input logic [31:0] x);
		xfer(1'b0, ix, '0);
		cmp(rd, x);
	endtask
	// run slots, then let the pipeline drain
	task runs(input int n, input string s);
		@(posedge core_clk);
		run <= 1'b1;
		repeat (n) @(posedge core_clk);
		run <= 1'b0;
		repeat (4) @(posedge core_clk);
		cmp(exp_q.size(), 0);
		$display("test %s done", s);
	endtask
	// expected result of each slot, from shadow registers
	always @(posedge core_clk) if (nrst && slot_valid)
		exp_q.push_back({slot_channel, serial_ctrl_pins & ~msk[5:1],
			prio ? ract : (ract | hw
			| (flexible_serial_pin && !msk[0] ? psel : 6'h00)
			| (channel_control_stream[0] ? fsel : 6'h00))});
	// other hardware requests, random where enabled
	always @(posedge core_clk) hw <= fcsm_act_s'(6'($urandom) & hwm);
	// compare each result with the oldest note
	always @(negedge core_clk) if (nrst && act_valid) begin
		e = exp_q.size() ? exp_q.pop_front() : 16'hFFFF;
		cmpa({act_channel, serial_pins_eff, act_out}, e);
	end
	initial begin
		void'($urandom(32'hEF95F48B));
		repeat (10) @(posedge core_clk);
		nrst <= 1'b1;
		rdc(8'h6B, 32'h3F);
		rdc(8'h6C, 32'h00);
		rdc(8'h6D, 32'h00);
		rdc(8'h6F, 32'hFE);
		cmp({monitor_one_sel, monitor_two_sel}, 8'hFE);
		rdc(8'h7F, 32'h00);
		$display("test reset done");
		xfer(1'b1, 8'h73, 32'hA5);
		xfer(1'b1, 8'h70, 32'h0);
		xfer(1'b1, 8'h71, 32'h0);
		psel = 6'h3F;
		xfer(1'b1, 8'h6C, psel);
		runs(40, "masked pin");
		xfer(1'b1, 8'h73, 32'h00);
		xfer(1'b1, 8'h6C, 32'h00);
		rdc(8'h6C, 32'h3F);
		xfer(1'b1, 8'h73, 32'hA5);
		for (int b = 0; b < 6; b++) begin
			msk = 6'($urandom) & 6'h3E;
			psel = 6'(1 << b);
			fsel = 6'(32 >> b);
			xfer(1'b1, 8'h6B, msk);
			xfer(1'b1, 8'h6C, psel);
			xfer(1'b1, 8'h6D, fsel);
			rdc(8'h6D, fsel);
			runs(30, "one action");
		end
		psel = 6'h00;
		fsel = 6'h21;
		xfer(1'b1, 8'h6C, psel);
		xfer(1'b1, 8'h6D, fsel);
		xfer(1'b1, 8'h72, 32'h3);
		runs(30, "clear channel");
		hwm = 6'h3F;
		ract = 6'h15;
		xfer(1'b1, 8'h71, 32'h15);
		runs(30, "hardware or");
		prio = 1'b1;
		xfer(1'b1, 8'h70, 32'hFFFFFFFF);
		runs(30, "priority");
		m = 8'($urandom);
		xfer(1'b1, 8'h6F, m);
		@(negedge core_clk);
		cmp({monitor_one_sel, monitor_two_sel}, m);
		print_verdict();
	end
endmodule
